// File: tcm_pkg.sv
package tcm_pkg;
   localparam logic [6:0] CTRL_OFS = 7'h00;
   localparam logic [6:0] DEG_OFS = 7'h04;
   localparam logic [6:0] EXP_OFS = 7'h08;
   localparam logic [6:0] ACC_OFS = 7'h18;
   localparam logic [6:0] STAT_OFS = 7'h28;
   localparam logic [6:0] IRQ_STAT_OFS = 7'h2C;
   localparam logic [6:0] IRQ_MASK_OFS = 7'h30;
   localparam logic [6:0] PM_NEAR_OFS = 7'h34;
   localparam logic [6:0] PM_FAR_OFS = 7'h38;
   localparam logic [6:0] PM_OFAR_OFS = 7'h3C;
   localparam logic [6:0] PM_DS_OFS = 7'h40;
   localparam int CTRL_MON_BIT = 0;
   localparam int CTRL_RDI_BIT = 1;
   localparam int CTRL_ODI_BIT = 2;
   localparam int CTRL_MISMATCH_DISABLE_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h7;
   localparam logic [19:0] DEG_RESET = 20'h1000A;
   localparam logic [15:0] FAS_PATTERN = 16'hFFFE;
   localparam logic [6:0] MF_LEN = 7'h4C;
   localparam logic [6:0] FAS_LAST = 7'h08;
   localparam logic [6:0] TRACE_FIRST = 7'h09;
   localparam logic [6:0] TRACE_LAST = 7'h48;
   localparam logic [6:0] RDI_FRAME = 7'h49;
   localparam logic [6:0] ODI_FRAME = 7'h4A;
   typedef struct packed {
      logic clk;
      logic frame_start;
      logic ssf;
      logic [7:0] data;
   } link_type;
   typedef struct packed {
      logic unequipped;
      logic tandem_loss;
      logic trace_mismatch;
      logic degraded;
      logic remote_defect;
      logic outgoing_defect;
   } cause_type;
endpackage : tcm_pkg

// File: tandem_monitor_sink.sv
`timescale 1ns/1ps
`default_nettype none
module persist_filt #(parameter int N = 5) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic stb,
   input wire logic sample,
   output logic state_q
);
   logic [3:0] run_q;
   initial assert (N >= 1 && N <= 15) else $error("persistence count out of range");
   // state flips only after N consecutive opposite samples
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         run_q <= 4'h0;
         state_q <= 1'b0;
      end else if (stb) begin
         if (sample == state_q) begin
            run_q <= 4'h0;
         end else if (run_q == 4'(N - 1)) begin
            run_q <= 4'h0;
            state_q <= sample;
         end else begin
            run_q <= run_q + 4'h1;
         end
      end
   end
endmodule : persist_filt

////////////////////////////////////////////////////////////////////////////////
module tandem_monitor_sink import tcm_pkg::*; #(
   parameter int FRAME_BYTES = 140,
   parameter int N2_POS = 70,
   parameter int PERSIST = 5,
   parameter int ACCEPT = 3,
   parameter int LTC_MISS = 2
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic link_frame_start,
   input wire logic link_ssf,
   input wire logic [7:0] link_data,
   input wire logic equipment_defect,
   input wire logic one_second,
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   output logic trail_fail_action,
   output logic trail_degrade_action,
   output cause_type fault_cause
);
   initial assert (N2_POS > 0 && N2_POS < FRAME_BYTES && FRAME_BYTES < 256 && ACCEPT < 16 && LTC_MISS < 16)
      else $error("bad frame or count parameters");

   ////////////////////////////////////////////////////////////////////////////
   // the stream is only tapped; no data path leaves this block
   link_type ls1_q, ls2_q;
   logic clk3_q;
   logic byte_stb;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ls1_q <= '0;
         ls2_q <= '0;
         clk3_q <= 1'b0;
      end else begin
         ls1_q <= '{link_clk, link_frame_start, link_ssf, link_data};
         ls2_q <= ls1_q;
         clk3_q <= ls2_q.clk;
      end
   end
   assign byte_stb = ls2_q.clk & ~clk3_q;

   logic [7:0] byte_cnt_q;
   logic [1:0] bip_acc_q, bip_prev_q;
   logic [1:0] byte_bip;
   logic n2_stb;
   logic [7:0] n2;
   assign byte_bip = {ls2_q.data[7] ^ ls2_q.data[5] ^ ls2_q.data[3] ^ ls2_q.data[1],
                      ls2_q.data[6] ^ ls2_q.data[4] ^ ls2_q.data[2] ^ ls2_q.data[0]};
   assign n2 = ls2_q.data;
   assign n2_stb = byte_stb && !ls2_q.frame_start && byte_cnt_q == 8'(N2_POS);
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         byte_cnt_q <= 8'h00;
         bip_acc_q <= 2'h0;
         bip_prev_q <= 2'h0;
      end else if (byte_stb) begin
         if (ls2_q.frame_start) begin
            byte_cnt_q <= 8'h01;
            bip_prev_q <= bip_acc_q;
            bip_acc_q <= byte_bip;
         end else begin
            byte_cnt_q <= byte_cnt_q + 8'h01;
            bip_acc_q <= bip_acc_q ^ byte_bip;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // multiframe alignment on N2[7-8] and loss of tandem connection
   logic [15:0] fas_sh_q, fas_new;
   logic [6:0] mfi_q, frame_no;
   logic aligned_q, tandem_loss_q;
   logic [3:0] miss_q;
   assign fas_new = {fas_sh_q[13:0], n2[1:0]};
   assign frame_no = (mfi_q == MF_LEN) ? 7'h01 : mfi_q + 7'h01;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         fas_sh_q <= 16'h0000;
         mfi_q <= 7'h00;
         aligned_q <= 1'b0;
         tandem_loss_q <= 1'b1;
         miss_q <= 4'h0;
      end else if (n2_stb) begin
         fas_sh_q <= fas_new;
         if (fas_new == FAS_PATTERN) begin
            mfi_q <= FAS_LAST;
            aligned_q <= 1'b1;
            tandem_loss_q <= 1'b0;
            miss_q <= 4'h0;
         end else begin
            mfi_q <= frame_no;
            if (frame_no == FAS_LAST) begin
               if (miss_q == 4'(LTC_MISS - 1)) begin
                  tandem_loss_q <= 1'b1;
                  aligned_q <= 1'b0;
               end else begin
                  miss_q <= miss_q + 4'h1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trace: 64 frames x 2 bits, accepted after ACCEPT identical multiframes
   logic [127:0] trace_sh_q, trace_prev_q, accepted_q, trace_new;
   logic [3:0] trace_run_q;
   logic [3:0] ctrl_q;
   logic [127:0] expected_q;
   logic trace_mismatch_q;
   assign trace_new = {trace_sh_q[125:0], n2[1:0]};
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         trace_sh_q <= '0;
         trace_prev_q <= '0;
         accepted_q <= '0;
         trace_run_q <= 4'h0;
      end else if (n2_stb && aligned_q && frame_no >= TRACE_FIRST && frame_no <= TRACE_LAST) begin
         trace_sh_q <= trace_new;
         if (frame_no == TRACE_LAST) begin
            trace_prev_q <= trace_new;
            if (trace_new != trace_prev_q) begin
               trace_run_q <= 4'h1;
            end else if (trace_run_q != 4'(ACCEPT)) begin
               trace_run_q <= trace_run_q + 4'h1;
               if (trace_run_q == 4'(ACCEPT - 1)) begin
                  accepted_q <= trace_new;
               end
            end
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         trace_mismatch_q <= 1'b0;
      end else begin
         trace_mismatch_q <= !ctrl_q[CTRL_MISMATCH_DISABLE_BIT] && accepted_q != expected_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // N2 bit defects filtered over consecutive receptions
   logic unequipped_defect, incoming_ais_defect, remote_defect_det, outgoing_defect_det;
   logic rdi_stb, odi_stb;
   assign rdi_stb = n2_stb && aligned_q && frame_no == RDI_FRAME;
   assign odi_stb = n2_stb && aligned_q && frame_no == ODI_FRAME;
   persist_filt #(.N(PERSIST)) une_f (.mclk(mclk), .nrst(nrst), .stb(n2_stb),
      .sample(n2 == 8'h00), .state_q(unequipped_defect));
   persist_filt #(.N(PERSIST)) ais_f (.mclk(mclk), .nrst(nrst), .stb(n2_stb),
      .sample(n2[4]), .state_q(incoming_ais_defect));
   persist_filt #(.N(PERSIST)) rdi_f (.mclk(mclk), .nrst(nrst), .stb(rdi_stb),
      .sample(n2[0]), .state_q(remote_defect_det));
   persist_filt #(.N(PERSIST)) odi_f (.mclk(mclk), .nrst(nrst), .stb(odi_stb),
      .sample(n2[1]), .state_q(outgoing_defect_det));

   logic near_err, far_err, ofar_err;
   assign near_err = n2_stb && (n2[7:6] != bip_prev_q);
   assign far_err = n2_stb && n2[3];
   assign ofar_err = n2_stb && n2[2];

   ////////////////////////////////////////////////////////////////////////////
   // degrade: bad second when errors exceed threshold, state after M seconds
   logic [19:0] deg_q;
   logic [15:0] deg_err_q;
   logic [3:0] deg_run_q;
   logic degraded_q, bad_sec;
   assign bad_sec = deg_err_q > deg_q[15:0];
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         deg_err_q <= 16'h0000;
         deg_run_q <= 4'h0;
         degraded_q <= 1'b0;
      end else if (one_second) begin
         deg_err_q <= {15'h0000, near_err};
         if (bad_sec == degraded_q) begin
            deg_run_q <= 4'h0;
         end else if (deg_run_q + 4'h1 >= deg_q[19:16]) begin
            deg_run_q <= 4'h0;
            degraded_q <= bad_sec;
         end else begin
            deg_run_q <= deg_run_q + 4'h1;
         end
      end else if (near_err && deg_err_q != 16'hFFFF) begin
         deg_err_q <= deg_err_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // consequent actions and correlation
   logic mon, fail_now;
   cause_type cause_d;
   assign mon = ctrl_q[CTRL_MON_BIT];
   assign fail_now = ls2_q.ssf | unequipped_defect | trace_mismatch_q | tandem_loss_q;
   always_comb begin
      cause_d.unequipped = unequipped_defect & mon;
      cause_d.tandem_loss = !unequipped_defect & tandem_loss_q;
      cause_d.trace_mismatch = trace_mismatch_q & !unequipped_defect & !tandem_loss_q & mon;
      cause_d.degraded = degraded_q & !trace_mismatch_q & !tandem_loss_q & mon;
      cause_d.remote_defect = remote_defect_det & !unequipped_defect & !trace_mismatch_q & !tandem_loss_q
         & mon & ctrl_q[CTRL_RDI_BIT];
      cause_d.outgoing_defect = outgoing_defect_det & !unequipped_defect & !trace_mismatch_q & !tandem_loss_q
         & mon & ctrl_q[CTRL_ODI_BIT];
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         trail_fail_action <= 1'b0;
         trail_degrade_action <= 1'b0;
         fault_cause <= '0;
      end else begin
         trail_fail_action <= fail_now;
         trail_degrade_action <= degraded_q;
         fault_cause <= cause_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-second primitives; counters saturate rather than wrap
   logic [15:0] near_acc_q, far_acc_q, ofar_acc_q, pm_near_q, pm_far_q, pm_ofar_q;
   logic [2:0] ds_acc_q, pm_ds_q, ds_now;
   assign ds_now = {outgoing_defect_det, remote_defect_det, trail_fail_action | equipment_defect};
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         near_acc_q <= 16'h0000;
         far_acc_q <= 16'h0000;
         ofar_acc_q <= 16'h0000;
         ds_acc_q <= 3'h0;
         pm_near_q <= 16'h0000;
         pm_far_q <= 16'h0000;
         pm_ofar_q <= 16'h0000;
         pm_ds_q <= 3'h0;
      end else if (one_second) begin
         pm_near_q <= near_acc_q;
         pm_far_q <= far_acc_q;
         pm_ofar_q <= ofar_acc_q;
         pm_ds_q <= ds_acc_q | ds_now;
         near_acc_q <= {15'h0000, near_err};
         far_acc_q <= {15'h0000, far_err};
         ofar_acc_q <= {15'h0000, ofar_err};
         ds_acc_q <= 3'h0;
      end else begin
         if (near_err && near_acc_q != 16'hFFFF) near_acc_q <= near_acc_q + 16'h0001;
         if (far_err && far_acc_q != 16'hFFFF) far_acc_q <= far_acc_q + 16'h0001;
         if (ofar_err && ofar_acc_q != 16'hFFFF) ofar_acc_q <= ofar_acc_q + 16'h0001;
         ds_acc_q <= ds_acc_q | ds_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: rising causes set sticky bits, set beats write-one clear
   cause_type cause_old_q;
   logic [5:0] irq_stat_q, irq_mask_q, irq_clr;
   logic wr_take, rd_take;
   assign wr_take = avs_write && !avs_waitrequest;
   assign rd_take = (avs_read || avs_write) && avs_waitrequest;
   assign irq_clr = (wr_take && avs_address == IRQ_STAT_OFS && avs_byteenable[0]) ? avs_writedata[5:0] : 6'h00;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cause_old_q <= '0;
         irq_stat_q <= 6'h00;
         irq <= 1'b0;
      end else begin
         cause_old_q <= fault_cause;
         irq_stat_q <= (irq_stat_q & ~irq_clr) | (fault_cause & ~cause_old_q);
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait state, readdata valid when waitrequest drops
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction : merge

   logic [1:0] word_idx;
   assign word_idx = avs_address[3:2] - 2'h2;
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (avs_address)
         CTRL_OFS: rdata = {28'h0000000, ctrl_q};
         DEG_OFS: rdata = {12'h000, deg_q};
         EXP_OFS, EXP_OFS + 7'h04, EXP_OFS + 7'h08, EXP_OFS + 7'h0C: rdata = expected_q[32*word_idx +: 32];
         ACC_OFS, ACC_OFS + 7'h04, ACC_OFS + 7'h08, ACC_OFS + 7'h0C:
            rdata = accepted_q[32*word_idx +: 32];
         STAT_OFS: rdata = {16'h0000, 1'b0, incoming_ais_defect, outgoing_defect_det, remote_defect_det,
            degraded_q, trace_mismatch_q, tandem_loss_q, unequipped_defect, 2'h0, fault_cause};
         IRQ_STAT_OFS: rdata = {26'h0000000, irq_stat_q};
         IRQ_MASK_OFS: rdata = {26'h0000000, irq_mask_q};
         PM_NEAR_OFS: rdata = {16'h0000, pm_near_q};
         PM_FAR_OFS: rdata = {16'h0000, pm_far_q};
         PM_OFAR_OFS: rdata = {16'h0000, pm_ofar_q};
         PM_DS_OFS: rdata = {29'h00000000, pm_ds_q};
         default: rdata = 32'h0000_0000;
      endcase
   end

   logic [31:0] ctrl_w, deg_w, mask_w, exp_w;
   assign ctrl_w = merge({28'h0000000, ctrl_q}, avs_writedata, avs_byteenable);
   assign deg_w = merge({12'h000, deg_q}, avs_writedata, avs_byteenable);
   assign mask_w = merge({26'h0000000, irq_mask_q}, avs_writedata, avs_byteenable);
   assign exp_w = merge(expected_q[32*word_idx +: 32], avs_writedata, avs_byteenable);
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !rd_take;
         if (rd_take && avs_read) avs_readdata <= rdata;
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET;
         deg_q <= DEG_RESET;
         irq_mask_q <= 6'h00;
         expected_q <= '0;
      end else if (wr_take) begin
         if (avs_address == CTRL_OFS) ctrl_q <= ctrl_w[3:0];
         if (avs_address == DEG_OFS) deg_q <= deg_w[19:0];
         if (avs_address == IRQ_MASK_OFS) irq_mask_q <= mask_w[5:0];
         if (avs_address[6:4] == 3'h0 && avs_address[3:2] >= 2'h2) expected_q[32*word_idx +: 32] <= exp_w;
         if (avs_address[6:4] == 3'h1 && avs_address[3:2] <= 2'h1) expected_q[32*word_idx +: 32] <= exp_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   fail_map_a: assert property (@(posedge mclk) disable iff (!nrst)
      fail_now |=> trail_fail_action) else $error("trail fail not raised");
   deg_map_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(degraded_q) |=> trail_degrade_action ##1 $stable(trail_degrade_action) or !degraded_q)
      else $error("degrade action missing");
   uneq_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
      fault_cause.unequipped |-> $past(unequipped_defect) && $past(mon)) else $error("bad unequipped cause");
   ltc_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
      $past(nrst) && $past(tandem_loss_q) && !$past(unequipped_defect) |-> fault_cause.tandem_loss)
      else $error("loss cause missing");
   tim_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
      fault_cause.trace_mismatch |-> !$past(unequipped_defect) && !$past(tandem_loss_q) && $past(mon))
      else $error("bad mismatch cause");
   deg_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
      fault_cause.degraded |-> !$past(trace_mismatch_q) && !$past(tandem_loss_q) && $past(degraded_q))
      else $error("bad degrade cause");
   rdi_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
      fault_cause.remote_defect |-> $past(ctrl_q[CTRL_RDI_BIT]) && $past(remote_defect_det))
      else $error("bad remote cause");
   odi_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
      fault_cause.outgoing_defect |-> $past(ctrl_q[CTRL_ODI_BIT]) && !$past(trace_mismatch_q))
      else $error("bad outgoing cause");
   pm_latch_a: assert property (@(posedge mclk) disable iff (!nrst)
      one_second |=> pm_near_q == $past(near_acc_q) && pm_far_q == $past(far_acc_q)) else $error("pm not latched");
   bus_ack_a: assert property (@(posedge mclk) disable iff (!nrst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");
endmodule : tandem_monitor_sink
`default_nettype wire

// File: link_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// upstream byte source: continuous frames, N2 built from the controls below
module link_source_model import tcm_pkg::*; #(
   parameter int FRAME_BYTES = 8,
   parameter int N2_POS = 2
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [127:0] trace,
   input wire logic ais,
   input wire logic rdi,
   input wire logic odi,
   input wire logic uneq,
   input wire logic ssf,
   input wire logic arm,
   input wire logic [3:0] err_n,
   input wire logic [2:0] err_sel,
   output link_type link
);
   logic [2:0] ph_q;
   logic [7:0] byte_q;
   logic [6:0] frame_q;
   logic [1:0] acc_q;
   logic [1:0] bip_q;
   logic [3:0] left_q;
   logic [1:0] mf;
   logic [2:0] bad;
   logic [7:0] cur;
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      bad = (left_q != 4'h0) ? err_sel : 3'h0;
      if (frame_q <= FAS_LAST) mf = FAS_PATTERN[16 - 2 * int'(frame_q) +: 2];
      else if (frame_q <= TRACE_LAST) mf = trace[126 - 2 * (int'(frame_q) - 9) +: 2];
      else if (frame_q == RDI_FRAME) mf = {1'b0, rdi};
      else if (frame_q == ODI_FRAME) mf = {odi, 1'b0};
      else mf = 2'h0;
      // non-overhead bytes vary so the parity really depends on the whole frame
      cur = byte_q ^ 8'h5A;
      if (byte_q == 8'(N2_POS)) cur = uneq ? 8'h00 : {bip_q ^ {2{bad[2]}}, 1'b1, ais, bad[1], bad[0], mf};
   end
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ph_q <= 3'h0;
         byte_q <= 8'h00;
         frame_q <= 7'h01;
         acc_q <= 2'h0;
         bip_q <= 2'h0;
         left_q <= 4'h0;
         link <= '0;
      end else begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == 3'h7) link.clk <= 1'b1;
         // data changes on the falling link edge, half a byte before it is sampled
         if (ph_q == 3'h3) begin
            link.clk <= 1'b0;
            link.data <= cur;
            link.frame_start <= (byte_q == 8'h00);
            link.ssf <= ssf;
            acc_q <= ((byte_q == 8'h00) ? 2'h0 : acc_q) ^ {^(cur & 8'hAA), ^(cur & 8'h55)};
            if (byte_q == 8'h00) bip_q <= acc_q;
            if (byte_q == 8'(FRAME_BYTES - 1)) begin
               byte_q <= 8'h00;
               frame_q <= (frame_q == MF_LEN) ? 7'h01 : frame_q + 7'h01;
            end else begin
               byte_q <= byte_q + 8'h01;
            end
            if (byte_q == 8'(N2_POS) && left_q != 4'h0) left_q <= left_q - 4'h1;
         end
         if (arm) left_q <= err_n;
      end
   end
endmodule : link_source_model
`default_nettype wire

// File: tandem_monitor_sink_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH %0t %s", $time, msg); end end
module tandem_monitor_sink_test import tcm_pkg::*;;
   localparam int MF = 76 * 64;
   localparam logic [127:0] TRACE = 128'h0123456789ABCDEFFEDCBA9876543210;
   logic mclk = 1'b0, nrst = 1'b0, equipment_defect = 1'b0, one_second = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic arm = 1'b0, ais = 1'b0, rdi = 1'b0, odi = 1'b0, uneq = 1'b0, ssf = 1'b0, irq, tfa, tda, avs_waitrequest;
   logic [6:0] avs_address = 7'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0] err_n = 4'h0;
   logic [3:0] be = 4'hF;
   logic [2:0] err_sel = 3'h0;
   cause_type fault_cause;
   link_type link;
   int error_cnt = 0, total_checks = 0;
   link_source_model #(.FRAME_BYTES(8), .N2_POS(2)) link_source_model_i (.mclk(mclk), .nrst(nrst), .trace(TRACE),
      .ais(ais), .rdi(rdi), .odi(odi), .uneq(uneq), .ssf(ssf), .arm(arm), .err_n(err_n), .err_sel(err_sel), .link(link));
   // short frames keep a multiframe near five thousand cycles
   tandem_monitor_sink #(.FRAME_BYTES(8), .N2_POS(2), .PERSIST(2)) tandem_monitor_sink_i (.mclk(mclk), .nrst(nrst),
      .link_clk(link.clk), .link_frame_start(link.frame_start), .link_ssf(link.ssf), .link_data(link.data),
      .equipment_defect(equipment_defect), .one_second(one_second), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .trail_fail_action(tfa), .trail_degrade_action(tda),
      .fault_cause(fault_cause));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
      `CHK(n < 50, 1'b1, "bus answer missing")
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e, "register read")
   endtask : rdchk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic sec();
      @(posedge mclk) one_second <= 1'b1;
      @(posedge mclk) one_second <= 1'b0;
   endtask : sec
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (70000) @(posedge mclk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      cyc(12);
      nrst <= 1'b1;
      cyc(4);
      `CHK(tfa, 1'b1, "fail before alignment")
      `CHK(fault_cause, 6'b010000, "loss cause before alignment")
      rdchk(CTRL_OFS, 32'h7);
      rdchk(DEG_OFS, 32'h1000A);
      rdchk(7'h7C, 32'h0);
      wr(ACC_OFS, 32'hFFFFFFFF);
      for (int k = 0; k < 4; k++) wr(EXP_OFS + 7'(4 * k), TRACE[32 * k +: 32]);
      // only lane 0 enabled: the upper lanes must keep their reset contents
      be <= 4'h1;
      wr(DEG_OFS, 32'hFFFFFF02);
      be <= 4'hF;
      rdchk(DEG_OFS, 32'h10002);
      cyc(5 * MF);
      for (int k = 0; k < 4; k++) rdchk(ACC_OFS + 7'(4 * k), TRACE[32 * k +: 32]);
      `CHK(fault_cause, 6'b000000, "causes after alignment")
      `CHK(tfa, 1'b0, "fail after alignment")
      $display("test align done");
      // one second with three errors of each kind against a threshold of two
      sec();
      err_n <= 4'h3;
      err_sel <= 3'b111;
      arm <= 1'b1;
      @(posedge mclk) arm <= 1'b0;
      equipment_defect <= 1'b1;
      cyc(7 * 64);
      sec();
      cyc(5);
      rdchk(PM_NEAR_OFS, 32'h3);
      rdchk(PM_FAR_OFS, 32'h3);
      rdchk(PM_OFAR_OFS, 32'h3);
      rdchk(PM_DS_OFS, 32'h1);
      `CHK(tda, 1'b1, "degrade action")
      `CHK(fault_cause, 6'b000100, "degraded cause")
      equipment_defect <= 1'b0;
      sec();
      cyc(5);
      `CHK(tda, 1'b0, "degrade clears")
      rdchk(PM_NEAR_OFS, 32'h0);
      $display("test performance done");
      wr(EXP_OFS, ~TRACE[31:0]);
      cyc(MF);
      `CHK(fault_cause, 6'b001000, "mismatch cause")
      `CHK(tfa, 1'b1, "fail on mismatch")
      wr(CTRL_OFS, 32'hF);
      cyc(100);
      `CHK(fault_cause, 6'b000000, "mismatch disabled")
      `CHK(tfa, 1'b0, "fail with mismatch disabled")
      wr(CTRL_OFS, 32'h7);
      wr(EXP_OFS, TRACE[31:0]);
      $display("test mismatch done");
      wr(IRQ_STAT_OFS, 32'h3F);
      wr(IRQ_MASK_OFS, 32'h2);
      rdi <= 1'b1;
      odi <= 1'b1;
      cyc(3 * MF);
      `CHK(fault_cause, 6'b000011, "remote and outgoing causes")
      `CHK(irq, 1'b1, "interrupt raised")
      rdchk(IRQ_STAT_OFS, 32'h3);
      wr(IRQ_STAT_OFS, 32'h2);
      cyc(3);
      `CHK(irq, 1'b0, "interrupt cleared")
      rdchk(IRQ_STAT_OFS, 32'h1);
      wr(CTRL_OFS, 32'h1);
      cyc(3);
      `CHK(fault_cause, 6'b000000, "reports disabled")
      rdchk(STAT_OFS, 32'h3000);
      sec();
      sec();
      cyc(3);
      rdchk(PM_DS_OFS, 32'h6);
      $display("test remote done");
      ais <= 1'b1;
      ssf <= 1'b1;
      cyc(10 * 64);
      rdchk(STAT_OFS, 32'h7000);
      `CHK(tfa, 1'b1, "fail on server fail")
      `CHK(fault_cause, 6'b000000, "server fail is no cause")
      ais <= 1'b0;
      ssf <= 1'b0;
      $display("test ais done");
      wr(CTRL_OFS, 32'h7);
      uneq <= 1'b1;
      cyc(6 * 64);
      `CHK(fault_cause, 6'b100000, "unequipped cause alone")
      `CHK(tfa, 1'b1, "fail on unequipped")
      wr(CTRL_OFS, 32'h6);
      cyc(3);
      `CHK(fault_cause, 6'b000000, "monitoring off")
      `CHK(tfa, 1'b1, "fail without monitoring")
      $display("test unequipped done");
      end_of_test();
   end
endmodule : tandem_monitor_sink_test
`default_nettype wire
